// ### logic/fls_pkg.sv
package fls_pkg;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
  localparam logic [7:0] CMD_LOCK_CONF = 8'h01;
  localparam logic [7:0] CMD_LOCKDOWN_CONF = 8'h2F;
  localparam logic [7:0] CMD_SET_CONF = 8'h03;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam int NUM_BANKS = 8;
  localparam int BANK_W = 3;

  typedef enum logic [1:0] {
    FLS_OUT_ARRAY,
    FLS_OUT_STATUS,
    FLS_OUT_SIG,
    FLS_OUT_QUERY
  } fls_out_t;

  typedef enum {
    FLS_READY,
    FLS_LOCK_SETUP,
    FLS_OTP_SETUP,
    FLS_OTP_BUSY,
    FLS_PROG_SETUP,
    FLS_PROG_BUSY,
    FLS_PROG_SUSP,
    FLS_ERASE_SETUP,
    FLS_ERASE_BUSY,
    FLS_ERASE_SUSP,
    FLS_ES_PROG_SETUP,
    FLS_ES_PROG_BUSY,
    FLS_ES_PROG_SUSP,
    FLS_ES_LOCK_SETUP,
    FLS_FBW_SETUP,
    FLS_FBW_BUSY,
    FLS_FBW_VERIFY,
    FLS_FBW4_SETUP,
    FLS_FBW4_BUSY
  } fls_state_t;
endpackage : fls_pkg

// ### logic/fls_bank_mode.sv
`timescale 1ns/1ps
module fls_bank_mode (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic addressed,
  output fls_pkg::fls_out_t mode
);
  import fls_pkg::*;
  fls_out_t next_mode;

  // only the mode-selecting codes touch the bank; others leave it alone
  always_comb begin
    next_mode = mode;
    if (cmd_valid && addressed) begin
      case (cmd_data)
        CMD_READ_ARRAY: next_mode = FLS_OUT_ARRAY;
        CMD_READ_STATUS: next_mode = FLS_OUT_STATUS;
        CMD_READ_SIG: next_mode = FLS_OUT_SIG;
        CMD_READ_QUERY: next_mode = FLS_OUT_QUERY;
        default: next_mode = mode;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= FLS_OUT_ARRAY;
    end else begin
      mode <= next_mode;
    end
  end
endmodule : fls_bank_mode

// ### logic/fls_cmd_fsm.sv
`timescale 1ns/1ps
module fls_cmd_fsm (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic [fls_pkg::BANK_W-1:0] cmd_bank,
  input wire logic fbw_exit,
  input wire logic op_done,
  output logic [fls_pkg::NUM_BANKS*2-1:0] bank_modes,
  output logic [4:0] state_code,
  output logic lock_error,
  output logic op_error,
  output logic lock_strobe,
  output logic bank_read_undefined
);
  import fls_pkg::*;

  logic rst_s1;
  logic rst_s2;
  fls_state_t state;
  fls_state_t next_state;
  logic next_lock_error;
  logic next_op_error;
  logic next_lock_strobe;
  logic next_undef;
  logic pe_active;
  logic pe_busy_or_susp;
  logic [NUM_BANKS*2-1:0] modes_w;

  // reset release through two flops so all state leaves reset together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  function automatic logic is_lock_confirm(input logic [7:0] d);
    is_lock_confirm = (d == CMD_LOCK_CONF) || (d == CMD_LOCKDOWN_CONF) ||
                      (d == CMD_SET_CONF);
  endfunction : is_lock_confirm

  // one accepted write cycle carrying the given code
  function automatic logic takes(input logic v, input logic [7:0] d,
                                 input logic [7:0] code);
    takes = v && (d == code);
  endfunction : takes

  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : g_bank
      fls_out_t m;
      fls_bank_mode u_mode (
        .clk(clk),
        .rst_b(rst_s2),
        .cmd_valid(cmd_valid),
        .cmd_data(cmd_data),
        .addressed(cmd_bank == BANK_W'(g)),
        .mode(m)
      );
      assign modes_w[g*2 +: 2] = m;
    end
  endgenerate

  always_comb begin
    pe_active = (state == FLS_PROG_BUSY) || (state == FLS_ERASE_BUSY) ||
                (state == FLS_ES_PROG_BUSY) || (state == FLS_OTP_BUSY) ||
                (state == FLS_FBW_BUSY) || (state == FLS_FBW4_BUSY);
    pe_busy_or_susp = pe_active || (state == FLS_PROG_SUSP) ||
                      (state == FLS_ERASE_SUSP) ||
                      (state == FLS_ES_PROG_SUSP);
  end

  // next state looks only at state and inputs, never at bank modes
  always_comb begin
    next_state = state;
    next_lock_error = lock_error;
    next_op_error = op_error;
    next_lock_strobe = 1'b0;
    next_undef = 1'b0;
    if (takes(cmd_valid, cmd_data, CMD_CLEAR_STATUS) &&
        !pe_busy_or_susp) begin
      next_lock_error = 1'b0;
      next_op_error = 1'b0;
    end
    // flag only; the array path itself is not modelled here
    if (takes(cmd_valid, cmd_data, CMD_READ_ARRAY) && pe_active) begin
      next_undef = 1'b1;
    end
    case (state)
      FLS_READY: begin
        if (takes(cmd_valid, cmd_data, CMD_LOCK_SETUP)) begin
          next_state = FLS_LOCK_SETUP;
        end else if (takes(cmd_valid, cmd_data, CMD_OTP_SETUP)) begin
          next_state = FLS_OTP_SETUP;
        end
      end
      FLS_LOCK_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_READY;
          if (is_lock_confirm(cmd_data)) begin
            next_lock_strobe = 1'b1;
          end else begin
            next_lock_error = 1'b1;
          end
        end
      end
      FLS_OTP_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_OTP_BUSY;
        end
      end
      // lock codes arriving while busy are dropped, both cycles
      FLS_OTP_BUSY: begin
        if (op_done) begin
          next_state = FLS_READY;
        end
      end
      FLS_PROG_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_PROG_BUSY;
        end
      end
      FLS_PROG_BUSY: begin
        if (op_done) begin
          next_state = FLS_READY;
        end
      end
      FLS_PROG_SUSP: begin
        next_state = FLS_PROG_SUSP;
      end
      FLS_ERASE_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_READY;
          next_op_error = 1'b1;
        end
      end
      FLS_ERASE_BUSY: begin
        if (op_done) begin
          next_state = FLS_READY;
        end
      end
      FLS_ERASE_SUSP: begin
        if (takes(cmd_valid, cmd_data, CMD_LOCK_SETUP)) begin
          next_state = FLS_ES_LOCK_SETUP;
        end
      end
      FLS_ES_LOCK_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_ERASE_SUSP;
          if (is_lock_confirm(cmd_data)) begin
            next_lock_strobe = 1'b1;
          end else begin
            next_lock_error = 1'b1;
          end
        end
      end
      FLS_ES_PROG_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_ES_PROG_BUSY;
        end
      end
      FLS_ES_PROG_BUSY: begin
        if (op_done) begin
          next_state = FLS_ERASE_SUSP;
        end
      end
      FLS_ES_PROG_SUSP: begin
        next_state = FLS_ES_PROG_SUSP;
      end
      FLS_FBW_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_READY;
          next_op_error = 1'b1;
        end
      end
      // x4 setup has no error exit: any cycle starts the burst
      FLS_FBW4_SETUP: begin
        if (cmd_valid) begin
          next_state = FLS_FBW4_BUSY;
        end
      end
      FLS_FBW_BUSY: begin
        if (cmd_valid && fbw_exit) begin
          next_state = FLS_FBW_VERIFY;
        end
      end
      FLS_FBW_VERIFY: begin
        if ((cmd_valid && fbw_exit) || op_done) begin
          next_state = FLS_READY;
        end
      end
      FLS_FBW4_BUSY: begin
        if ((cmd_valid && fbw_exit) || op_done) begin
          next_state = FLS_READY;
        end
      end
      default: begin
        next_state = FLS_READY;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= FLS_READY;
      lock_error <= 1'b0;
      op_error <= 1'b0;
      lock_strobe <= 1'b0;
      bank_read_undefined <= 1'b0;
      bank_modes <= '0;
      state_code <= 5'h00;
    end else begin
      state <= next_state;
      lock_error <= next_lock_error;
      op_error <= next_op_error;
      lock_strobe <= next_lock_strobe;
      bank_read_undefined <= next_undef;
      bank_modes <= modes_w;
      state_code <= 5'(next_state);
    end
  end
endmodule : fls_cmd_fsm

// ### test/fls_host.sv
`timescale 1ns/1ps
module fls_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  output logic [2:0] cmd_bank
);
  initial begin
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    cmd_bank = 3'h0;
  end
  // caller keeps the bank across both cycles of a pair
  task automatic send(input logic [2:0] b, input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_data = d;
    cmd_bank = b;
    @(posedge clk);
    #1;
  endtask : send
  // released data inverts so a stale value cannot pass
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_data = ~cmd_data;
    @(posedge clk);
    #1;
  endtask : idle
endmodule : fls_host

// ### test/fls_chk_props.sv
`timescale 1ns/1ps
module fls_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic [2:0] cmd_bank,
  input wire logic op_done,
  input wire logic [15:0] bank_modes,
  input wire logic [4:0] state_code,
  input wire logic lock_error,
  input wire logic lock_strobe,
  input wire logic bank_read_undefined
);
  import fls_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire rdy = state_code == 5'h00;
  wire bsy = state_code == 5'h03;
  wire ok = cmd_data == 8'h01 || cmd_data == 8'h2F || cmd_data == 8'h03;
  sequence s_lk(bit g);
    state_code == 5'h01 && cmd_valid && ok == g;
  endsequence
  property p_mode(logic [7:0] c, logic [1:0] m);
    logic [2:0] b;
    (rdy && cmd_valid && cmd_data == c, b = cmd_bank) |->
      ##2 bank_modes[2*b +: 2] == m;
  endproperty
  reset_clean_a: assert property (
    $rose(rst_b) |-> rdy && bank_modes == 0)
    else $error("reset state wrong");
  lock_enter_a: assert property (
    rdy && cmd_valid && cmd_data == CMD_LOCK_SETUP |=> state_code == 5'h01)
    else $error("no lock setup");
  otp_enter_a: assert property (
    rdy && cmd_valid && cmd_data == CMD_OTP_SETUP |=> state_code == 5'h02)
    else $error("no otp setup");
  lock_good_a: assert property (
    s_lk(1) |=> rdy && lock_strobe)
    else $error("confirm lost");
  lock_bad_a: assert property (
    s_lk(0) |=> rdy && lock_error && !lock_strobe)
    else $error("bad confirm kept");
  otp_start_a: assert property (
    state_code == 5'h02 && cmd_valid |=> bsy)
    else $error("otp not busy");
  busy_hold_a: assert property (
    bsy && !op_done |=> bsy && !lock_strobe)
    else $error("busy left");
  busy_done_a: assert property (
    bsy && op_done |=> rdy)
    else $error("busy stuck");
  clear_hold_a: assert property (
    bsy && cmd_valid && cmd_data == CMD_CLEAR_STATUS |=>
      $stable(lock_error))
    else $error("flag cleared");
  read_undef_a: assert property (
    bsy && cmd_valid && cmd_data == CMD_READ_ARRAY |=>
      bank_read_undefined)
    else $error("no undefined flag");
  mode_status_a: assert property (
    p_mode(CMD_READ_STATUS, 2'h1))
    else $error("status mode");
  mode_sig_a: assert property (
    p_mode(CMD_READ_SIG, 2'h2))
    else $error("sig mode");
  mode_query_a: assert property (
    p_mode(CMD_READ_QUERY, 2'h3))
    else $error("query mode");
  mode_keep_a: assert property (
    !cmd_valid |-> ##2 $stable(bank_modes))
    else $error("mode drift");
endmodule : fls_chk
bind fls_cmd_fsm fls_chk fls_chk_inst (.clk, .rst_b, .cmd_valid, .cmd_data,
  .cmd_bank, .op_done, .bank_modes, .state_code, .lock_error, .lock_strobe,
  .bank_read_undefined);

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic op_done = 1'b0;
  logic fbw_exit = 1'b0;
  logic cmd_valid, lock_error, op_error, lock_strobe, bank_read_undefined;
  logic [7:0] cmd_data;
  logic [2:0] cmd_bank;
  logic [15:0] bank_modes;
  logic [4:0] state_code;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] codes [3] = '{8'h01, 8'h2F, 8'h03};
  fls_host fls_host_inst (.clk, .cmd_valid, .cmd_data, .cmd_bank);
  fls_cmd_fsm fls_cmd_fsm_inst (.clk, .rst_b, .cmd_valid, .cmd_data,
    .cmd_bank, .fbw_exit, .op_done, .bank_modes, .state_code,
    .lock_error, .op_error, .lock_strobe, .bank_read_undefined);
  initial forever #20 clk = ~clk;
  // tests take under fifty cycles; generous margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic t_modes();
    check("state", state_code, 5'h00);
    check("banks", bank_modes, 16'h0000);
    fls_host_inst.send(3, 8'h70);
    fls_host_inst.send(5, 8'h90);
    fls_host_inst.send(6, 8'h98);
    fls_host_inst.idle();
    fls_host_inst.idle();
    check("banks", bank_modes, 16'h3840);
    repeat (3) fls_host_inst.idle();
    check("banks", bank_modes, 16'h3840);
    fls_host_inst.send(5, 8'hFF);
    fls_host_inst.idle();
    fls_host_inst.idle();
    check("banks", bank_modes, 16'h3040);
    $display("end modes");
  endtask : t_modes
  // back to back pairs, bank 6 sits in query mode
  task automatic t_lock();
    foreach (codes[i]) begin
      fls_host_inst.send(6, 8'h60);
      check("state", state_code, 5'h01);
      fls_host_inst.send(6, codes[i]);
      check("state", state_code, 5'h00);
      check("strobe", lock_strobe, 1'b1);
    end
    fls_host_inst.idle();
    check("strobe", lock_strobe, 1'b0);
    check("lock err", lock_error, 1'b0);
    fls_host_inst.send(2, 8'h60);
    fls_host_inst.send(2, 8'h12);
    check("state", state_code, 5'h00);
    check("lock err", lock_error, 1'b1);
    check("op err", op_error, 1'b0);
    $display("end lock");
  endtask : t_lock
  task automatic t_otp();
    fls_host_inst.send(0, 8'hC0);
    check("state", state_code, 5'h02);
    fls_host_inst.send(0, 8'h55);
    check("state", state_code, 5'h03);
    fls_host_inst.send(0, 8'h60);
    fls_host_inst.send(0, 8'h01);
    check("state", state_code, 5'h03);
    check("strobe", lock_strobe, 1'b0);
    fbw_exit = 1'b1;
    fls_host_inst.send(0, 8'hFF);
    fbw_exit = 1'b0;
    check("undef", bank_read_undefined, 1'b1);
    check("state", state_code, 5'h03);
    fls_host_inst.send(0, 8'h50);
    check("lock err", lock_error, 1'b1);
    check("undef", bank_read_undefined, 1'b0);
    op_done = 1'b1;
    fls_host_inst.idle();
    op_done = 1'b0;
    check("state", state_code, 5'h00);
    fls_host_inst.send(0, 8'h50);
    fls_host_inst.idle();
    check("lock err", lock_error, 1'b0);
    $display("end otp");
  endtask : t_otp
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_modes();
    t_lock();
    t_otp();
    stop_test();
  end
endmodule : tb
